// File: core/ssync_pkg.sv
// Package: command codes, register fields and reset values for the slicer settings
package ssync_pkg;
    // ==========================================
    // Command framing
    localparam int unsigned ID_BIT = 7;
    localparam logic [7:0] CMD_ERROR_POLICY = 8'hf2;
    localparam logic [7:0] CMD_SYNC_THRESH = 8'hf3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================
    // Error policy register fields
    localparam int unsigned F_MASK_START = 6;
    localparam int unsigned F_MASK_LEN = 5;
    localparam int unsigned F_RUN_IN = 4;
    localparam int unsigned F_FRAMING = 3;
    localparam int unsigned F_BYPASS = 2;
    localparam int unsigned F_UNCHECKED_WR = 1;
    localparam int unsigned F_UNUSED_OFF = 0;
    // ==========================================
    // Sync threshold register fields
    localparam int unsigned F_ACQ_HI = 6;
    localparam int unsigned F_ACQ_LO = 4;
    localparam int unsigned F_LOSS_HI = 3;
    localparam int unsigned F_LOSS_LO = 0;
    // Line counts
    localparam logic [8:0] MASK_EARLY_LINES = 9'h00a;
    localparam logic [8:0] MASK_FIXED_LINES = 9'h009;
    localparam logic [2:0] RUN_IN_SHORT = 3'h2;
    localparam logic [2:0] RUN_IN_LONG = 3'h4;
    // ==========================================
    // Wishbone register map of the host controller
    localparam logic [3:0] WB_CMD_OFS = 4'h0;
    localparam logic [3:0] WB_STAT_OFS = 4'h4;
    // Decoded line threshold for acquire, with alternate flag
    function automatic logic [8:0] ssync_acq_lines(input logic [2:0] code,
                                                    input logic alt);
        logic [8:0] n;
        n = 9'h000;
        case (code)
            3'h0: n = alt ? 9'h020 : 9'h000;
            3'h1: n = alt ? 9'h040 : 9'h004;
            3'h2: n = alt ? 9'h080 : 9'h008;
            3'h4: n = alt ? 9'h100 : 9'h010;
            default: n = 9'h000;
        endcase
        return n;
    endfunction
    // Decoded line threshold for loss; zero means no detection
    function automatic logic [8:0] ssync_loss_lines(input logic [3:0] code);
        logic [8:0] n;
        n = 9'h000;
        case (code)
            4'h1: n = 9'h020;
            4'h2: n = 9'h040;
            4'h4: n = 9'h080;
            4'h8: n = 9'h100;
            default: n = 9'h000;
        endcase
        return n;
    endfunction
endpackage

// File: core/ssync_cmd_if.sv
// Interface: byte command stream from host to slicer
interface ssync_cmd_if;
    logic byteValid;
    logic [7:0] byteData;
    logic byteReady;
    modport host (output byteValid, output byteData, input byteReady);
    modport dev (input byteValid, input byteData, output byteReady);
endinterface

// File: core/ssync_settings.sv
// Device end: two-byte command decoder and the two settings registers
// ==========================================
// Summary of operation
// RULE1 - First byte has bit 7 set
// RULE2 - Second byte bit 7 clear, loads low seven
// RULE3 - Code f2 targets error policy register
// RULE4 - Code f3 targets sync threshold register
// RULE5 - Reset clears both registers
// RULE6 - Bit 6 starts mask ten lines early
// RULE7 - Bit 5 fixes mask length nine lines
// RULE8 - Bit 4 picks run-in check 2 or 4
// RULE9 - Bit 3 tolerates one bad framing bit
// RULE10 - Checking on: clean checked bytes transferred
// RULE11 - Bypass: all bytes transferred
// RULE12 - Bit 1 holds or writes unchecked errored bytes
// RULE13 - Biphase VPS, Hamming PDC, parity header
// RULE14 - Bit 0 disables checks on unused bytes
// RULE15 - Header unused byte ranges per mode
// RULE16 - Status display unused byte ranges
// RULE17 - Acquire codes give 0,4,8,16 lines
// RULE18 - Alternate flag gives 32..256 lines
// RULE19 - Loss one-hot codes give 32..256 lines
// RULE20 - Loss code zero disables loss detection
// RULE21 - Host writes only listed codes; the host here forwards any code with bit 7 set
// RULE22 - Alternate flag clear uses normal values
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
module ssync_settings
    import ssync_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    ssync_cmd_if.dev cmd,
    input wire logic alternateThresholdSel,
    output logic maskStartEarlySel,
    output logic maskLengthSel,
    output logic runInCheckCountSel,
    output logic framingToleranceSel,
    output logic errorCheckBypass,
    output logic uncheckedByteWriteSel,
    output logic unusedByteCheckOff,
    output logic [8:0] maskEarlyLines,
    output logic [8:0] maskFixedLines,
    output logic [2:0] runInRepeats,
    output logic [8:0] acquireLines,
    output logic [8:0] lossLines,
    output logic lossDetectEnable,
    output logic [7:0] errorPolicy,
    output logic [7:0] syncThresholds
);
    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_ERR = 2'b01,
        SS_SYNC = 2'b10
    } ssync_state_t;

    ssync_state_t state_reg, state_next;
    logic [7:0] errPol_reg, errPol_next;
    logic [7:0] syncTh_reg, syncTh_next;

    // ==========================================
    // Code match for a first byte
    // Used for both command codes, so the compare is written once
    function automatic logic code_hit(input logic [7:0] b,
                                      input logic [7:0] code);
        return b == code;
    endfunction

    // ==========================================
    // Byte classification
    // The link always accepts, so a valid byte is a taken byte
    wire logic take = cmd.byteValid;
    wire logic isFirst = cmd.byteData[ID_BIT]; // RULE1
    wire logic isErrCmd = code_hit(cmd.byteData, CMD_ERROR_POLICY); // RULE3
    wire logic isSyncCmd = code_hit(cmd.byteData, CMD_SYNC_THRESH); // RULE4
    // Bit 7 of the loaded value is forced clear
    wire logic [7:0] payload = {1'b0, cmd.byteData[6:0]}; // RULE2

    assign cmd.byteReady = 1'b1;

    // Decoder: a first byte always restarts a command
    // Unknown first bytes park in idle, so a stray second byte
    // that follows them can never reach either register
    always_comb begin
        state_next = state_reg;
        errPol_next = errPol_reg;
        syncTh_next = syncTh_reg;
        if (take) begin
            if (isFirst) begin // RULE1
                if (isErrCmd)
                    state_next = SS_ERR;
                else if (isSyncCmd)
                    state_next = SS_SYNC;
                else
                    state_next = SS_IDLE;
            end else begin
                state_next = SS_IDLE;
                case (state_reg)
                    SS_ERR: errPol_next = payload; // RULE2 RULE3
                    SS_SYNC: syncTh_next = payload; // RULE2 RULE4
                    SS_IDLE: state_next = SS_IDLE;
                    default: state_next = SS_IDLE;
                endcase
            end
        end
    end

    // State and registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= SS_IDLE;
            errPol_reg <= REG_RESET; // RULE5
            syncTh_reg <= REG_RESET; // RULE5
        end else begin
            state_reg <= state_next;
            errPol_reg <= errPol_next;
            syncTh_reg <= syncTh_next;
        end
    end

    // ==========================================
    // Settings fanned out to the slicer datapath
    assign maskStartEarlySel = errPol_reg[F_MASK_START]; // RULE6
    assign maskLengthSel = errPol_reg[F_MASK_LEN]; // RULE7
    assign runInCheckCountSel = errPol_reg[F_RUN_IN]; // RULE8
    assign framingToleranceSel = errPol_reg[F_FRAMING]; // RULE9
    assign errorCheckBypass = errPol_reg[F_BYPASS]; // RULE10 RULE11
    assign uncheckedByteWriteSel = errPol_reg[F_UNCHECKED_WR]; // RULE12
    // Unused-byte ranges and decode kind live in the datapath
    // The datapath applies this bit to each mode's own byte range
    // RULE13 RULE15 RULE16
    assign unusedByteCheckOff = errPol_reg[F_UNUSED_OFF]; // RULE14
    assign maskEarlyLines = maskStartEarlySel ? MASK_EARLY_LINES
                                              : 9'h000; // RULE6
    assign maskFixedLines = maskLengthSel ? MASK_FIXED_LINES
                                          : 9'h000; // RULE7
    assign runInRepeats = runInCheckCountSel ? RUN_IN_LONG
                                             : RUN_IN_SHORT; // RULE8
    // Line thresholds for the sync discriminator
    // Alternate flag is a level from outside, so this follows it at once
    // RULE17 RULE18 RULE22
    assign acquireLines = ssync_acq_lines(syncTh_reg[F_ACQ_HI:F_ACQ_LO],
                                          alternateThresholdSel);
    // Unlisted codes give zero lines
    assign lossLines =
        ssync_loss_lines(syncTh_reg[F_LOSS_HI:F_LOSS_LO]); // RULE19
    assign lossDetectEnable = |syncTh_reg[F_LOSS_HI:F_LOSS_LO]; // RULE20
    assign errorPolicy = errPol_reg;
    assign syncThresholds = syncTh_reg;
endmodule // ssync_settings

// File: core/ssync_host.sv
// Host end: Wishbone slave that issues two-byte commands to the slicer
module ssync_host
    import ssync_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ssync_cmd_if.host cmd
);
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_FIRST = 2'b01,
        SH_SECOND = 2'b10
    } ssync_hstate_t;

    ssync_hstate_t state_reg, state_next;
    logic [7:0] code_reg;
    logic [6:0] value_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] byte_reg;
    logic valid_reg;

    // ==========================================
    // Bus decode; write to command: [15:8] code, [6:0] settings
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic hitCmd = wb_adr_i == WB_CMD_OFS;
    wire logic busy = state_reg != SH_IDLE;
    wire logic launch = req & wb_we_i & hitCmd & ~busy & (&wb_sel_i[1:0]);
    wire logic [31:0] rdata = (wb_adr_i == WB_STAT_OFS) ? {31'h0, busy}
                            : hitCmd ? {16'h0, code_reg, 1'b0, value_reg}
                            : 32'h0;

    // Sequencer: first byte, then second byte
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SH_IDLE: if (launch) state_next = SH_FIRST;
            SH_FIRST: state_next = SH_SECOND;
            SH_SECOND: state_next = SH_IDLE;
            default: state_next = SH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= SH_IDLE;
            code_reg <= REG_RESET;
            value_reg <= 7'h00;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
            byte_reg <= REG_RESET;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ack_reg <= req;
            rdat_reg <= rdata;
            valid_reg <= state_next != SH_IDLE;
            if (launch) begin
                code_reg <= wb_dat_i[15:8] | 8'h80; // RULE1
                value_reg <= wb_dat_i[6:0];
            end
            if (state_next == SH_FIRST)
                byte_reg <= wb_dat_i[15:8] | 8'h80; // RULE1 RULE3 RULE4
            else if (state_next == SH_SECOND)
                byte_reg <= {1'b0, value_reg}; // RULE2 RULE21
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign cmd.byteValid = valid_reg;
    assign cmd.byteData = byte_reg;
endmodule // ssync_host

// File: sim/ssync_monitor.sv
// Checker: assertions on the command link and the settings outputs
module ssync_monitor
    import ssync_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    input wire logic byteReady,
    input wire logic alternateThresholdSel,
    input wire logic [7:0] errorPolicy,
    input wire logic [7:0] syncThresholds,
    input wire logic [8:0] acquireLines,
    input wire logic [8:0] lossLines,
    input wire logic lossDetectEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Target picked by the last first byte
    logic [1:0] tgt_reg;
    logic [1:0] tgt_next;
    wire logic isFirst = byteValid && byteData[7];
    wire logic isSecond = byteValid && !byteData[7];
    wire logic [2:0] acqCode = syncThresholds[6:4];
    wire logic [3:0] lossCode = syncThresholds[3:0];
    assign tgt_next = (byteData == CMD_ERROR_POLICY) ? 2'h1 :
                      (byteData == CMD_SYNC_THRESH) ? 2'h2 : 2'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            tgt_reg <= 2'h0;
        else if (isFirst)
            tgt_reg <= tgt_next;
        else if (isSecond)
            tgt_reg <= 2'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Assertions
    AST_READY: assert property (byteReady)
        else $error("link refused a byte");
    AST_POL_LOAD: assert property (isSecond && tgt_reg == 2'h1 |=>
        errorPolicy == ($past(byteData) & 8'h7f)) else $error("policy load");
    AST_SYN_LOAD: assert property (isSecond && tgt_reg == 2'h2 |=>
        syncThresholds == ($past(byteData) & 8'h7f)) else $error("sync load");
    AST_POL_HOLD: assert property (!(isSecond && tgt_reg == 2'h1) |=>
        $stable(errorPolicy)) else $error("policy changed");
    AST_SYN_HOLD: assert property (!(isSecond && tgt_reg == 2'h2) |=>
        $stable(syncThresholds)) else $error("sync changed");
    AST_CLEAR: assert property ($fell(rst) |->
        errorPolicy == 8'h00 && syncThresholds == 8'h00) else $error("no clear");
    AST_ACQ_NORM: assert property (!alternateThresholdSel &&
        acqCode inside {0, 1, 2, 4} |-> acquireLines == {4'h0, acqCode, 2'h0})
        else $error("acquire count");
    AST_ACQ_ALT: assert property (alternateThresholdSel &&
        acqCode inside {0, 1, 2, 4} |-> acquireLines ==
        (acqCode == 3'h0 ? 9'h020 : {acqCode, 6'h00})) else $error("alt count");
    AST_LOSS: assert property (lossCode inside {0, 1, 2, 4, 8} |->
        lossLines == {lossCode, 5'h00}) else $error("loss count");
    AST_LOSS_OFF: assert property (
        lossDetectEnable == (lossCode != 4'h0)) else $error("loss enable");
    AST_BIT7: assert property (!errorPolicy[7] && !syncThresholds[7])
        else $error("bit 7 set");
endmodule // ssync_monitor

// File: sim/ssync_tb_top.sv
// Testbench: host and slicer ends joined by the link, driven over Wishbone
module ssync_tb_top
    import ssync_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, alt = 1'b0;
    logic [3:0] wbAdr = 4'h0, wbSel = 4'h0, lc;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic maskStartEarlySel, maskLengthSel, runInCheckCountSel;
    logic framingToleranceSel, errorCheckBypass, uncheckedByteWriteSel;
    logic unusedByteCheckOff, lossDetectEnable;
    logic [8:0] maskEarlyLines, maskFixedLines, acquireLines, lossLines;
    logic [7:0] errorPolicy, syncThresholds, fltPol, fltSyn, seed = 8'h0f;
    logic [6:0] v;
    logic [2:0] runInRepeats, ac;
    int nErrors = 0, testsRun = 0;
    ssync_cmd_if lnk();
    ssync_cmd_if flt();
    always #10 ref_clk = ~ref_clk;
    ssync_host ssync_host_inst (.ref_clk, .rst, .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .cmd(lnk));
    ssync_settings ssync_settings_inst (.ref_clk, .rst, .cmd(lnk),
        .alternateThresholdSel(alt), .maskStartEarlySel, .maskLengthSel,
        .runInCheckCountSel, .framingToleranceSel, .errorCheckBypass,
        .uncheckedByteWriteSel, .unusedByteCheckOff, .maskEarlyLines,
        .maskFixedLines, .runInRepeats, .acquireLines, .lossLines,
        .lossDetectEnable, .errorPolicy, .syncThresholds);
    // Second slicer end fed with faulty byte streams
    ssync_settings ssync_settings_flt_inst (.ref_clk, .rst, .cmd(flt),
        .alternateThresholdSel(1'b0), .maskStartEarlySel(), .maskLengthSel(),
        .runInCheckCountSel(), .framingToleranceSel(), .errorCheckBypass(),
        .uncheckedByteWriteSel(), .unusedByteCheckOff(), .maskEarlyLines(),
        .maskFixedLines(), .runInRepeats(), .acquireLines(), .lossLines(),
        .lossDetectEnable(), .errorPolicy(fltPol), .syncThresholds(fltSyn));
    ssync_monitor ssync_monitor_inst (.ref_clk, .rst,
        .byteValid(lnk.byteValid), .byteData(lnk.byteData),
        .byteReady(lnk.byteReady), .alternateThresholdSel(alt), .errorPolicy,
        .syncThresholds, .acquireLines, .lossLines, .lossDetectEnable);
    // ==========================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [8:0] eacq(input logic [2:0] c, input logic a);
        return (a && c == 3'h0) ? 9'h020 : a ? {c, 6'h0} : {4'h0, c, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {wbCyc, wbStb, wbWe, wbSel} <= {2'b11, we, 4'hf};
        {wbAdr, wbDatI} <= {a, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 40);
        rd = wbDatO;
        chk(n < 40, 1'b1);
        {wbCyc, wbStb} <= 2'b00;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [6:0] val);
        int n;
        n = 0;
        wb(1'b1, WB_CMD_OFS, {16'h0, code, 1'b0, val});
        do begin
            wb(1'b0, WB_STAT_OFS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
    endtask
    task automatic fb(input logic [7:0] b);
        @(posedge ref_clk);
        {flt.byteValid, flt.byteData} <= {1'b1, b};
        @(posedge ref_clk);
        {flt.byteValid, flt.byteData} <= {1'b0, ~b};
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {flt.byteValid, flt.byteData} = 9'h000;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        chk({errorPolicy, syncThresholds, runInRepeats}, 19'h2);
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : seed[6:0];
            cmd(CMD_ERROR_POLICY, v);
            chk(errorPolicy, {1'b0, v});
            chk({maskStartEarlySel, maskLengthSel, runInCheckCountSel,
                framingToleranceSel, errorCheckBypass, uncheckedByteWriteSel,
                unusedByteCheckOff}, v);
            chk(maskEarlyLines, v[6] ? 9'h00a : 9'h000);
            chk(maskFixedLines, v[5] ? 9'h009 : 9'h000);
            chk(runInRepeats, v[4] ? 3'h4 : 3'h2);
        end
        for (int a = 0; a < 4; a++) begin
            for (int l = 0; l < 5; l++) begin
                seed = lfsr(seed);
                ac = (a == 3) ? 3'h4 : 3'(a);
                lc = (l == 0) ? 4'h0 : 4'(1 << (l - 1));
                alt <= seed[0];
                cmd(CMD_SYNC_THRESH, {ac, lc});
                chk({syncThresholds, errorPolicy},
                    {1'b0, ac, lc, 1'b0, v});
                chk(acquireLines, eacq(ac, seed[0]));
                chk({lossDetectEnable, lossLines},
                    {lc != 0, lc, 5'h0});
            end
        end
        cmd(8'hf1, 7'h55);
        chk({syncThresholds, errorPolicy}, {8'h48, 1'b0, v});
        wb(1'b1, 4'h8, 32'hffff_ffff);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        // Stray second byte, restarted command, extra and unlisted bytes
        fb(8'h35);
        fb(8'hf2);
        fb(8'hf3);
        fb(8'h2a);
        fb(8'h11);
        fb(8'hf1);
        fb(8'h7f);
        @(posedge ref_clk);
        chk({fltPol, fltSyn}, 16'h002a);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({errorPolicy, syncThresholds, fltSyn}, 24'h0);
        rst <= 1'b0;
        results();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk);
        nErrors++;
        results();
    end
endmodule // ssync_tb_top
